// [sim/ptc_mgmt_ctrl.sv]
// Management controller model that issues decoded frames to the register block
`timescale 1ns/1ps
module ptc_mgmt_ctrl
    import ptc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rvalid_in,
    input wire logic [15:0] rdata_in,
    output ptc_mgmt_req_t req_out
);
    initial req_out = '0;
    // ****************************************
    // One frame, held over exactly one rising edge
    // ****************************************
    task automatic access(input logic w, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic ok, output logic [15:0] q);
        @(negedge clk_in);
        req_out.wr = w;
        req_out.rd = !w;
        req_out.phy_addr = pa;
        req_out.reg_addr = ra;
        req_out.wdata = wd & ((ra == 5'h1B) ? 16'hFF7F : 16'hFFFE);
        @(negedge clk_in);
        ok = rvalid_in;
        q = rdata_in;
        req_out.wr = 1'b0;
        req_out.rd = 1'b0;
        // Released data lines do not keep the last word
        req_out.wdata = ~req_out.wdata;
    endtask
endmodule

// [sim/ptc_regs_properties.sv]
// Concurrent checks on the ports of the test and control register block
`timescale 1ns/1ps
module ptc_regs_properties
    import ptc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input ptc_pkg::ptc_mgmt_req_t mgmt_req_in,
    input wire logic [4:0] local_phy_addr_in,
    input wire logic mgmt_rvalid_out,
    input wire logic mode_clocks_on_in,
    input wire logic mii_tx_clk_en_out,
    input wire logic mii_rx_clk_en_out,
    input wire logic speed_100_in,
    input ptc_pkg::ptc_mac_mode_t mac_mode_in,
    input wire logic runaway_guard_off_in,
    input wire logic tx_clk_from_rx_out,
    input wire logic aux_pin_rx_clock_out,
    input wire logic jabber_active_out,
    input wire logic soft_reset_out,
    input wire logic line_pattern_active_out,
    input wire logic line_pattern_seq_start_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // ****************************************
    // Properties
    // ****************************************
    property p_rd_answer;
        mgmt_req_in.rd && mgmt_req_in.phy_addr == local_phy_addr_in |=> mgmt_rvalid_out;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_foreign;
        mgmt_req_in.rd && mgmt_req_in.phy_addr != local_phy_addr_in |=> !mgmt_rvalid_out;
    endproperty
    a_rd_foreign: assert property (p_rd_foreign) else $error("foreign read answered");
    property p_mii_clk;
        mode_clocks_on_in |-> mii_tx_clk_en_out && mii_rx_clk_en_out;
    endproperty
    a_mii_clk: assert property (p_mii_clk) else $error("mode clocks dropped");
    property p_tx_lock;
        tx_clk_from_rx_out |-> speed_100_in &&
            mac_mode_in inside {PTC_MAC_MII, PTC_MAC_RMII_MASTER};
    endproperty
    a_tx_lock: assert property (p_tx_lock) else $error("tx locked wrongly");
    property p_aux_rx;
        aux_pin_rx_clock_out |-> speed_100_in;
    endproperty
    a_aux_rx: assert property (p_aux_rx) else $error("rx clock on aux at 10 Mb");
    property p_jabber;
        jabber_active_out == (!speed_100_in && !runaway_guard_off_in);
    endproperty
    a_jabber: assert property (p_jabber) else $error("jabber state wrong");
    property p_soft_len;
        $rose(soft_reset_out) |-> ##15 soft_reset_out ##1 !soft_reset_out;
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset length wrong");
    property p_patt_stop;
        soft_reset_out |=> !line_pattern_active_out;
    endproperty
    a_patt_stop: assert property (p_patt_stop) else $error("pattern kept on");
    property p_seq_pulse;
        line_pattern_seq_start_out |=> !line_pattern_seq_start_out;
    endproperty
    a_seq_pulse: assert property (p_seq_pulse) else $error("start pulse too long");
endmodule
bind ptc_regs ptc_regs_properties u_props (.sys_clk_in, .resetn_in, .mgmt_req_in,
    .local_phy_addr_in, .mgmt_rvalid_out, .mode_clocks_on_in, .mii_tx_clk_en_out,
    .mii_rx_clk_en_out, .speed_100_in, .mac_mode_in, .runaway_guard_off_in,
    .tx_clk_from_rx_out, .aux_pin_rx_clock_out, .jabber_active_out, .soft_reset_out,
    .line_pattern_active_out, .line_pattern_seq_start_out);

// [sim/testbench.sv]
// Self-checking bench for the test and control register block
`timescale 1ns/1ps
module testbench;
    import ptc_pkg::*;
    logic sys_clk_in = 0, resetn_in = 0, selftest_start_in = 0, selftest_running_in = 0;
    logic nibble_err_in = 0, speed_100_in = 0, mode_clocks_on_in = 0;
    logic runaway_guard_off_in = 1;
    logic [4:0] local_phy_addr_in = 5'h05;
    ptc_straps_t straps_in = 2'h3;
    ptc_mac_mode_t mac_mode_in = PTC_MAC_MII;
    ptc_mgmt_req_t mgmt_req_in;
    ptc_pattern_t line_pattern_kind_out;
    logic [15:0] mgmt_rdata_out, q;
    logic mgmt_rvalid_out, mii_tx_clk_en_out, mii_rx_clk_en_out, selftest_nonstop_out, ok;
    logic line_pattern_active_out, line_pattern_seq_start_out, mgmt_line_pullup_on_out;
    logic tx_clk_from_rx_out, aux_pin_rx_clock_out, aux_clock_pin_en_out, legacy_pinout_out;
    logic all_stations_write_on_out, soft_reset_out, jabber_active_out;
    int miscompares = 0, samples_checked = 0, p0, p1, n;
    always #2.5 sys_clk_in = ~sys_clk_in;
    ptc_regs dut (.*);
    ptc_mgmt_ctrl mc (.clk_in(sys_clk_in), .rvalid_in(mgmt_rvalid_out),
        .rdata_in(mgmt_rdata_out), .req_out(mgmt_req_in));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        mc.access(1'b1, pa, ra, d, ok, q);
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        mc.access(1'b0, 5'h05, ra, 16'h0, ok, q);
        chk1("rvalid", 1'b1, ok);
        chk("rdata", e, q);
    endtask
    task automatic pulse(input int k);
        @(negedge sys_clk_in);
        nibble_err_in = (k > 0);
        selftest_start_in = (k == 0);
        repeat ((k > 0) ? k : 1) @(negedge sys_clk_in);
        nibble_err_in = 0;
        selftest_start_in = 0;
    endtask
    task automatic period(output int c);
        int k;
        k = 0;
        while (line_pattern_seq_start_out !== 1'b1 && k < 8000) begin
            @(negedge sys_clk_in);
            k++;
        end
        c = 0;
        do begin
            @(negedge sys_clk_in);
            c++;
        end while (line_pattern_seq_start_out !== 1'b1 && c < 8000);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(negedge sys_clk_in);
        resetn_in = 1;
        rd(5'h1C, 16'h0402);
        chk1("aux_en", 0, aux_clock_pin_en_out);
        chk1("legacy", 1, legacy_pinout_out);
        wr(5'h05, 5'h1B, 16'hFFFF);
        rd(5'h1B, 16'h007F);
        chk1("nonstop", 1, selftest_nonstop_out);
        chk1("txclk", 1, mii_tx_clk_en_out & mii_rx_clk_en_out);
        wr(5'h05, 5'h1C, 16'hFDFF);
        rd(5'h1C, 16'h3C02);
        chk1("bcast", 1, all_stations_write_on_out);
        wr(5'h05, 5'h1B, 16'h0000);
        for (int m = 0; m < 16; m++) begin
            @(negedge sys_clk_in);
            speed_100_in = m[2];
            mac_mode_in = ptc_mac_mode_t'(m[1:0]);
            mode_clocks_on_in = m[0];
            runaway_guard_off_in = m[3];
            #1;
            chk1("tx_lock", m[2] && m[1:0] < 2, tx_clk_from_rx_out);
            chk1("aux_rx", m[2], aux_pin_rx_clock_out);
            chk1("jabber", !m[2] && !m[3], jabber_active_out);
            chk1("miiclk", m[0], mii_rx_clk_en_out);
        end
        wr(5'h1F, 5'h1B, 16'h0008);
        rd(5'h1B, 16'h0008);
        chk1("pullup", 1, mgmt_line_pullup_on_out);
        wr(5'h05, 5'h1C, 16'h0000);
        chk1("aux_en", 1, aux_clock_pin_en_out);
        wr(5'h1F, 5'h1B, 16'h0000);
        rd(5'h1B, 16'h0008);
        mc.access(1'b0, 5'h1F, 5'h1B, 16'h0, ok, q);
        chk1("bc_read", 0, ok);
        wr(5'h05, 5'h1C, 16'h0200);
        n = 0;
        while (soft_reset_out === 1'b1 && n < 40) begin
            n++;
            @(negedge sys_clk_in);
        end
        chk("soft_len", 16'd16, n[15:0]);
        rd(5'h1B, 16'h0008);
        rd(5'h1C, 16'h0000);
        wr(5'h05, 5'h1B, 16'h0000);
        selftest_running_in = 1;
        pulse(0);
        pulse(3);
        rd(5'h1B, 16'h0300);
        pulse(300);
        rd(5'h1B, 16'hFF00);
        pulse(0);
        rd(5'h1B, 16'h0000);
        wr(5'h05, 5'h1B, 16'h0010);
        period(p0);
        wr(5'h05, 5'h1B, 16'h0014);
        period(p1);
        // Send length cancels out; 5 us at 200 MHz remains
        chk("gap", 16'd1000, 16'(p1 - p0));
        for (int c = 0; c < 4; c++) begin
            wr(5'h05, 5'h1B, 16'h0000);
            wr(5'h05, 5'h1B, 16'h0010 | 16'(c));
            chk("kind", 16'(c), {14'h0, line_pattern_kind_out});
        end
        repeat (3) @(negedge sys_clk_in);
        n = 0;
        repeat (50) begin
            @(negedge sys_clk_in);
            n += (line_pattern_active_out === 1'b1);
        end
        chk("tone_busy", 16'd50, n[15:0]);
        wr(5'h05, 5'h1B, 16'h0000);
        @(negedge sys_clk_in);
        chk1("patt_off", 0, line_pattern_active_out);
        report_and_stop();
    end
endmodule

// [verilog/ptc_consts.svh]
// Offsets, field positions and timing counts of the test and control registers
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// ****************************************
// Register offsets and addressing
// ****************************************
`define PTC_OFS_LINE_TEST 5'h1B
`define PTC_OFS_EXTRA_CTRL 5'h1C
`define PTC_BCAST_PHY_ADDR 5'h1F

// ****************************************
// Fields of line_test_selftest_ext
// ****************************************
`define PTC_LT_ERR_HI 15
`define PTC_LT_ERR_LO 8
`define PTC_LT_RSVD7 7
`define PTC_LT_MII_CLK 6
`define PTC_LT_NONSTOP 5
`define PTC_LT_PATT_ON 4
`define PTC_LT_PULLUP 3
`define PTC_LT_SPACING 2
`define PTC_LT_CHOICE_HI 1
`define PTC_LT_CHOICE_LO 0
`define PTC_ERR_MAX 8'hFF

// ****************************************
// Fields of extra_phy_control
// ****************************************
`define PTC_XC_TX_LOCK 13
`define PTC_XC_AUX_RX 12
`define PTC_XC_BCAST 11
`define PTC_XC_COMPAT 10
`define PTC_XC_SOFT_RST 9
`define PTC_XC_AUX_OFF 1
`define PTC_XC_RSVD0 0

// ****************************************
// Timing
// ****************************************
`define PTC_CLK_MHZ 200
`define PTC_GAP_LONG_US 15
`define PTC_GAP_SHORT_US 10
`define PTC_GAP_LONG_CYC (`PTC_GAP_LONG_US * `PTC_CLK_MHZ)
`define PTC_GAP_SHORT_CYC (`PTC_GAP_SHORT_US * `PTC_CLK_MHZ)
`define PTC_SOFT_RST_CYC 16

`endif

// [verilog/ptc_pkg.sv]
// Types shared by the test and control register block
package ptc_pkg;

    typedef enum logic [1:0] {
        PTC_MAC_MII = 2'h0,
        PTC_MAC_RMII_MASTER = 2'h1,
        PTC_MAC_RMII_SLAVE = 2'h2,
        PTC_MAC_OTHER = 2'h3
    } ptc_mac_mode_t;

    typedef enum logic [1:0] {
        PTC_PATT_DATA_EOP0 = 2'h0,
        PTC_PATT_DATA_EOP1 = 2'h1,
        PTC_PATT_LINK_PULSE = 2'h2,
        PTC_PATT_TONE = 2'h3
    } ptc_pattern_t;

    typedef enum logic [2:0] {
        PTC_ST_IDLE = 3'h1,
        PTC_ST_SEND = 3'h2,
        PTC_ST_GAP = 3'h4
    } ptc_patt_state_t;

    // One decoded management frame
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] phy_addr;
        logic [4:0] reg_addr;
        logic [15:0] wdata;
    } ptc_mgmt_req_t;

    // Levels sampled while hard reset is held
    typedef struct packed {
        logic compat;
        logic aux_off;
    } ptc_straps_t;

endpackage

// [verilog/ptc_regs.sv]
// Test, self-test extension and extra control registers of the transceiver
`timescale 1ns/1ps
`include "ptc_consts.svh"

module ptc_regs (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input ptc_pkg::ptc_mgmt_req_t mgmt_req_in,
    input wire logic [4:0] local_phy_addr_in,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_rvalid_out,
    input ptc_pkg::ptc_straps_t straps_in,
    input wire logic selftest_start_in,
    input wire logic selftest_running_in,
    input wire logic nibble_err_in,
    input wire logic speed_100_in,
    input ptc_pkg::ptc_mac_mode_t mac_mode_in,
    input wire logic mode_clocks_on_in,
    input wire logic runaway_guard_off_in,
    output logic mii_tx_clk_en_out,
    output logic mii_rx_clk_en_out,
    output logic selftest_nonstop_out,
    output logic line_pattern_active_out,
    output ptc_pkg::ptc_pattern_t line_pattern_kind_out,
    output logic line_pattern_seq_start_out,
    output logic mgmt_line_pullup_on_out,
    output logic tx_clk_from_rx_out,
    output logic aux_pin_rx_clock_out,
    output logic aux_clock_pin_en_out,
    output logic legacy_pinout_out,
    output logic all_stations_write_on_out,
    output logic soft_reset_out,
    output logic jabber_active_out
);
    import ptc_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] err_tally_ff;
    logic [7:0] nxt_err_tally;
    logic rsvd7_ff;
    logic mii_clk_force_ff;
    logic nonstop_ff;
    logic patt_on_ff;
    logic pullup_ff;
    logic spacing_ff;
    logic [1:0] choice_ff;
    logic tx_lock_ff;
    logic aux_rx_ff;
    logic bcast_ff;
    logic compat_ff;
    logic aux_off_ff;
    logic rsvd0_ff;
    logic [4:0] srst_cnt_ff;
    logic [4:0] nxt_srst_cnt;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    ptc_patt_state_t patt_state_ff;
    ptc_patt_state_t nxt_patt_state;
    logic [11:0] gap_cnt_ff;
    logic [11:0] nxt_gap_cnt;
    logic seq_start_ff;
    logic nxt_seq_start;

    // ****************************************
    // Management access decode
    // ****************************************
    wire own_addr = mgmt_req_in.phy_addr == local_phy_addr_in;
    wire bcast_hit = bcast_ff && (mgmt_req_in.phy_addr == `PTC_BCAST_PHY_ADDR);
    wire wr_ok = mgmt_req_in.wr && (own_addr || bcast_hit);
    wire wr_lt = wr_ok && (mgmt_req_in.reg_addr == `PTC_OFS_LINE_TEST);
    wire wr_xc = wr_ok && (mgmt_req_in.reg_addr == `PTC_OFS_EXTRA_CTRL);
    wire rd_ok = mgmt_req_in.rd && own_addr;
    wire [15:0] wd = mgmt_req_in.wdata;
    wire soft_rst_active = srst_cnt_ff != 5'h00;

    // Reserved read-only ranges are simply not stored, so they read as zero
    wire [15:0] lt_word = {err_tally_ff, rsvd7_ff, mii_clk_force_ff, nonstop_ff, patt_on_ff,
                           pullup_ff, spacing_ff, choice_ff};
    wire [15:0] xc_word = {2'h0, tx_lock_ff, aux_rx_ff, bcast_ff, compat_ff, soft_rst_active,
                           7'h00, aux_off_ff, rsvd0_ff};
    wire [15:0] rd_word = (mgmt_req_in.reg_addr == `PTC_OFS_LINE_TEST) ? lt_word :
                          (mgmt_req_in.reg_addr == `PTC_OFS_EXTRA_CTRL) ? xc_word : 16'h0000;

    // ****************************************
    // Self-test nibble error tally
    // ****************************************
    always_comb begin
        nxt_err_tally = err_tally_ff;
        if (selftest_start_in || soft_rst_active) begin
            nxt_err_tally = 8'h00;
        end else if (selftest_running_in && nibble_err_in &&
                     err_tally_ff != `PTC_ERR_MAX) begin
            nxt_err_tally = err_tally_ff + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            err_tally_ff <= 8'h00;
        end else begin
            err_tally_ff <= nxt_err_tally;
        end
    end

    // ****************************************
    // Writable configuration bits
    // ****************************************
    // Soft reset never touches these; only hard reset does
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rsvd7_ff <= 1'b0;
            mii_clk_force_ff <= 1'b0;
            nonstop_ff <= 1'b0;
            patt_on_ff <= 1'b0;
            pullup_ff <= 1'b0;
            spacing_ff <= 1'b0;
            choice_ff <= 2'h0;
        end else if (wr_lt) begin
            rsvd7_ff <= wd[`PTC_LT_RSVD7];
            mii_clk_force_ff <= wd[`PTC_LT_MII_CLK];
            nonstop_ff <= wd[`PTC_LT_NONSTOP];
            patt_on_ff <= wd[`PTC_LT_PATT_ON];
            pullup_ff <= wd[`PTC_LT_PULLUP];
            spacing_ff <= wd[`PTC_LT_SPACING];
            choice_ff <= wd[`PTC_LT_CHOICE_HI:`PTC_LT_CHOICE_LO];
        end
    end

    // Strap bits follow their pins while hard reset is held, then software owns them
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tx_lock_ff <= 1'b0;
            aux_rx_ff <= 1'b0;
            bcast_ff <= 1'b0;
            compat_ff <= straps_in.compat;
            aux_off_ff <= straps_in.aux_off;
            rsvd0_ff <= 1'b0;
        end else if (wr_xc) begin
            tx_lock_ff <= wd[`PTC_XC_TX_LOCK];
            aux_rx_ff <= wd[`PTC_XC_AUX_RX];
            bcast_ff <= wd[`PTC_XC_BCAST];
            compat_ff <= wd[`PTC_XC_COMPAT];
            aux_off_ff <= wd[`PTC_XC_AUX_OFF];
            rsvd0_ff <= wd[`PTC_XC_RSVD0];
        end
    end

    // ****************************************
    // Self-clearing soft reset
    // ****************************************
    // Held for a fixed stretch so slow datapath blocks see it; the bit reads 1 meanwhile
    always_comb begin
        nxt_srst_cnt = srst_cnt_ff;
        if (wr_xc && wd[`PTC_XC_SOFT_RST]) begin
            nxt_srst_cnt = 5'(`PTC_SOFT_RST_CYC);
        end else if (soft_rst_active) begin
            nxt_srst_cnt = srst_cnt_ff - 5'h01;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            srst_cnt_ff <= 5'h00;
        end else begin
            srst_cnt_ff <= nxt_srst_cnt;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= rd_ok;
            if (rd_ok) begin
                rdata_ff <= rd_word;
            end
        end
    end

    // ****************************************
    // Line-driver pattern sequencer
    // ****************************************
    wire tone_sel = choice_ff == 2'(PTC_PATT_TONE);
    wire [11:0] gap_len = spacing_ff ? 12'(`PTC_GAP_LONG_CYC) :
                                       12'(`PTC_GAP_SHORT_CYC);

    always_comb begin
        nxt_patt_state = patt_state_ff;
        nxt_gap_cnt = gap_cnt_ff;
        nxt_seq_start = 1'b0;
        case (patt_state_ff)
            PTC_ST_IDLE: begin
                if (patt_on_ff) begin
                    nxt_patt_state = PTC_ST_SEND;
                    nxt_seq_start = 1'b1;
                end
            end
            PTC_ST_SEND: begin
                // The tone is a steady carrier, so it never pauses
                if (!tone_sel) begin
                    nxt_patt_state = PTC_ST_GAP;
                    nxt_gap_cnt = gap_len - 12'h001;
                end
            end
            PTC_ST_GAP: begin
                if (gap_cnt_ff == 12'h000) begin
                    nxt_patt_state = PTC_ST_SEND;
                    nxt_seq_start = 1'b1;
                end else begin
                    nxt_gap_cnt = gap_cnt_ff - 12'h001;
                end
            end
            default: begin
                nxt_patt_state = PTC_ST_IDLE;
            end
        endcase
        if (!patt_on_ff || soft_rst_active) begin
            nxt_patt_state = PTC_ST_IDLE;
            nxt_gap_cnt = 12'h000;
            nxt_seq_start = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            patt_state_ff <= PTC_ST_IDLE;
            gap_cnt_ff <= 12'h000;
            seq_start_ff <= 1'b0;
        end else begin
            patt_state_ff <= nxt_patt_state;
            gap_cnt_ff <= nxt_gap_cnt;
            seq_start_ff <= nxt_seq_start;
        end
    end

    // ****************************************
    // Control outputs to the datapath
    // ****************************************
    wire lock_mode_ok = (mac_mode_in == PTC_MAC_MII) || (mac_mode_in == PTC_MAC_RMII_MASTER);

    assign mgmt_rdata_out = rdata_ff;
    assign mgmt_rvalid_out = rvalid_ff;
    assign mii_tx_clk_en_out = mii_clk_force_ff || mode_clocks_on_in;
    assign mii_rx_clk_en_out = mii_clk_force_ff || mode_clocks_on_in;
    // Nonstop at 10 Mb relies on software having turned the jabber guard off first
    assign selftest_nonstop_out = nonstop_ff;
    assign line_pattern_active_out = patt_on_ff && !soft_rst_active &&
                                     patt_state_ff == PTC_ST_SEND;
    assign line_pattern_kind_out = ptc_pattern_t'(choice_ff);
    assign line_pattern_seq_start_out = seq_start_ff;
    assign mgmt_line_pullup_on_out = pullup_ff;
    assign tx_clk_from_rx_out = tx_lock_ff && speed_100_in && lock_mode_ok;
    assign aux_pin_rx_clock_out = aux_rx_ff && speed_100_in;
    // Only the disable bit gates the aux clock pin; the legacy pinout bit does not enable it
    assign aux_clock_pin_en_out = !aux_off_ff;
    assign legacy_pinout_out = compat_ff;
    assign all_stations_write_on_out = bcast_ff;
    assign soft_reset_out = soft_rst_active;
    assign jabber_active_out = !speed_100_in && !runaway_guard_off_in;

endmodule
